/* shared/sct_pkg.sv */
// constants shared by the secondary display controller and its raster generator
// assumes a 32-bit apb slave whose byte addresses are the register offsets
package sct_pkg;
  // register byte addresses
  localparam int          ADDR_W     = 20;
  localparam logic [19:0] OFF_CTRL   = 20'h80200;
  localparam logic [19:0] OFF_BASE   = 20'h80204;
  localparam logic [19:0] OFF_STRIDE = 20'h80208;
  localparam logic [19:0] OFF_HPER   = 20'h8020c;
  localparam logic [19:0] OFF_HPUL   = 20'h80210;
  localparam logic [19:0] OFF_VPER   = 20'h80214;
  localparam logic [19:0] OFF_VPUL   = 20'h80218;
  localparam logic [19:0] OFF_SIG    = 20'h8021c;
  localparam logic [19:0] OFF_LINE   = 20'h80220;
  localparam logic [19:0] OFF_SENSE  = 20'h80224;
  // reset values, undocumented ones are zero
  localparam logic [17:0] CTRL_RST   = 18'h10000;
  // control field positions
  localparam int C_FMT    = 0;
  localparam int C_PLANE  = 2;
  localparam int C_GAMMA  = 3;
  localparam int C_PAN    = 4;
  localparam int C_TIMING = 8;
  localparam int C_SRC    = 9;
  localparam int C_BLANK  = 10;
  localparam int C_HPOL   = 12;
  localparam int C_VPOL   = 13;
  localparam int C_MPOL   = 14;
  localparam int C_TPOL   = 15;
  localparam int C_LVL    = 16;
  // other field positions
  localparam int F_ADDR   = 4;
  localparam int W_WIDTH  = 20;
  localparam int W_STRIDE = 4;
  localparam int T_HI     = 16;
  localparam int S_SEL    = 0;
  localparam int S_RST    = 2;
  localparam int S_EN     = 3;
  localparam int L_EN     = 24;
  // pixel formats and analyzer channels
  localparam logic [1:0] FMT_IDX = 2'h0;
  localparam logic [1:0] FMT_565 = 2'h1;
  localparam logic [1:0] FMT_888 = 2'h2;
  localparam logic [1:0] CH_RED  = 2'h0;
  localparam logic [1:0] CH_GRN  = 2'h1;
  localparam logic [1:0] CH_BLU  = 2'h2;
  // signature feedback taps
  localparam logic [15:0] SIG_TAPS = 16'h1021;

  // empty entries needed before a fetch request
  function automatic logic [4:0] sct_level(input logic [1:0] code);
    sct_level = (code == 2'h0) ? 5'h01 : (code == 2'h1) ? 5'h03 :
                (code == 2'h2) ? 5'h07 : 5'h0b;
  endfunction : sct_level
endpackage : sct_pkg

/* shared/sct_raster_if.sv */
// signals between the display controller and its raster generator
// assumes both ends run on the same pclk
`timescale 1ns/1ps
interface sct_raster_if;
  logic        run;
  logic        pix_en;
  logic [11:0] h_period;
  logic [11:0] h_end;
  logic [11:0] h_begin;
  logic [7:0]  h_len;
  logic [10:0] v_period;
  logic [10:0] v_end;
  logic [10:0] v_begin;
  logic [5:0]  v_len;
  logic        active;
  logic        hpulse;
  logic        vpulse;
  logic        act_end;
  logic        last_line;
  modport ctl (output run, pix_en, h_period, h_end, h_begin, h_len,
               output v_period, v_end, v_begin, v_len,
               input active, hpulse, vpulse, act_end, last_line);
  modport gen (input run, pix_en, h_period, h_end, h_begin, h_len,
               input v_period, v_end, v_begin, v_len,
               output active, hpulse, vpulse, act_end, last_line);
endinterface : sct_raster_if

/* hdl/sct_raster.sv */
// pixel and line counters with raw sync and active area
// assumes pix_en is a one-cycle pulse per pixel on pclk
`timescale 1ns/1ps
module sct_raster (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // controller side
  sct_raster_if.gen t
);
  import sct_pkg::*;

  logic [11:0] h_q;
  logic [10:0] v_q;

  wire        h_wrap = (h_q == t.h_period);
  wire        v_wrap = (v_q == t.v_period);
  wire [12:0] h_stop = {1'b0, t.h_begin} + {5'h00, t.h_len};
  wire [11:0] v_stop = {1'b0, t.v_begin} + {6'h00, t.v_len};

  // counters wrap after the totals; stopped timing parks at the origin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      h_q <= 12'h000;
      v_q <= 11'h000;
    end else if (!t.run) begin
      h_q <= 12'h000;
      v_q <= 11'h000;
    end else if (t.pix_en) begin
      h_q <= h_wrap ? 12'h000 : h_q + 12'h001;
      if (h_wrap) begin
        v_q <= v_wrap ? 11'h000 : v_q + 11'h001;
      end
    end
  end

  // blanking beyond the display ends, pulses from start for their length
  assign t.active    = t.run && (h_q <= t.h_end) && (v_q <= t.v_end);
  assign t.hpulse    = t.run && (h_q >= t.h_begin) && ({1'b0, h_q} < h_stop);
  assign t.vpulse    = t.run && (v_q >= t.v_begin) && ({1'b0, v_q} < v_stop);
  assign t.act_end   = t.pix_en && t.active && (h_q == t.h_end);
  assign t.last_line = (v_q == t.v_end);
endmodule : sct_raster

/* hdl/sct_display.sv */
// secondary monitor pipeline: apb registers, frame fetch, pixel path, sync
// assumes a same-clock memory port and a free pixel clock from outside
`timescale 1ns/1ps
module sct_display #(
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [sct_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // frame memory read port
  output logic                            mem_req,
  output logic      [27:0]                mem_addr,
  input  wire logic                       mem_ack,
  input  wire logic [127:0]               mem_data,
  // pixel clock, panel pipeline data, load comparator
  input  wire logic                       pix_clk,
  input  wire logic [23:0]                panel_rgb,
  input  wire logic                       sense_hi,
  // monitor side
  output logic      [23:0]                rgb,
  output logic                            hsync,
  output logic                            vsync,
  output logic                            blank,
  output logic                            gamma_on,
  output logic                            mon_clk,
  output logic                            tv_clk
);
  import sct_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  sct_raster_if t ();

  // register state
  logic [17:0]   ctrl_q;
  logic [23:0]   base_q;
  logic          flip_q;
  logic [9:0]    win_q;
  logic [9:0]    stride_q;
  logic [11:0]   hper_q;
  logic [11:0]   hend_q;
  logic [11:0]   hbeg_q;
  logic [7:0]    hlen_q;
  logic [10:0]   vper_q;
  logic [10:0]   vend_q;
  logic [10:0]   vbeg_q;
  logic [5:0]    vlen_q;
  logic [15:0]   sig_q;
  logic [3:0]    sigc_q;
  logic          ld_en_q;
  logic [23:0]   ld_data_q;
  // synchronisers
  logic          pc_s1;
  logic          pc_s2;
  logic          pc_s3;
  logic          se_s1;
  logic          se_s2;
  // fetch and fifo state
  logic [1:0]    frm_sel_q;
  logic [21:0]   line_q;
  logic [21:0]   ptr_q;
  logic [9:0]    left_q;
  logic [10:0]   fline_q;
  logic          stale_q;
  logic [127:0]  fifo_mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic [3:0]    idx_q;

  // byte pixel unpacking; indexed pixels go out as grey, palette lies beyond
  function automatic logic [23:0] sct_pixel(input logic [127:0] u,
                                            input logic [3:0] i,
                                            input logic [1:0] f);
    logic [7:0]  b;
    logic [15:0] w;
    logic [31:0] d;
    b = u[{i, 3'h0} +: 8];
    w = u[{i[2:0], 4'h0} +: 16];
    d = u[{i[1:0], 5'h0} +: 32];
    if (f == FMT_565) begin
      sct_pixel = {w[15:11], w[15:13], w[10:5], w[10:9], w[4:0], w[4:2]};
    end else if (f == FMT_888) begin
      sct_pixel = d[23:0];
    end else begin
      sct_pixel = {b, b, b};
    end
  endfunction : sct_pixel

  // apb decode
  wire [19:0] a        = paddr;
  wire        hit      = (a == OFF_CTRL) || (a == OFF_BASE) || (a == OFF_STRIDE) ||
                         (a == OFF_HPER) || (a == OFF_HPUL) || (a == OFF_VPER) ||
                         (a == OFF_VPUL) || (a == OFF_SIG) || (a == OFF_LINE) ||
                         (a == OFF_SENSE);
  wire        access   = psel && penable;
  wire        wr       = access && pwrite && pready;
  wire        wr_ctrl  = wr && (a == OFF_CTRL);
  wire        wr_base  = wr && (a == OFF_BASE);
  wire        wr_strd  = wr && (a == OFF_STRIDE);
  wire        wr_hper  = wr && (a == OFF_HPER);
  wire        wr_hpul  = wr && (a == OFF_HPUL);
  wire        wr_vper  = wr && (a == OFF_VPER);
  wire        wr_vpul  = wr && (a == OFF_VPUL);
  wire        wr_sig   = wr && (a == OFF_SIG);
  wire        wr_sense = wr && (a == OFF_SENSE);

  // read selection; the vertical state bit is live, never stored
  wire [31:0] rd_ctrl  = {14'h0000, ctrl_q[17:12], t.vpulse, ctrl_q[10:0]};
  wire [31:0] rd_base  = {flip_q, 3'h0, base_q, 4'h0};
  wire [31:0] rd_strd  = {2'h0, win_q, 6'h00, stride_q, 4'h0};
  wire [31:0] rd_line  = {21'h000000, fline_q};
  wire [31:0] rd_sense = {6'h00, se_s2, ld_en_q, ld_data_q};
  wire [31:0] rd_mux   =
    (a == OFF_CTRL)   ? rd_ctrl :
    (a == OFF_BASE)   ? rd_base :
    (a == OFF_STRIDE) ? rd_strd :
    (a == OFF_HPER)   ? {4'h0, hper_q, 4'h0, hend_q} :
    (a == OFF_HPUL)   ? {8'h00, hlen_q, 4'h0, hbeg_q} :
    (a == OFF_VPER)   ? {5'h00, vper_q, 5'h00, vend_q} :
    (a == OFF_VPUL)   ? {10'h000, vlen_q, 5'h00, vbeg_q} :
    (a == OFF_SIG)    ? {sig_q, 12'h000, sigc_q} :
    (a == OFF_LINE)   ? rd_line :
    (a == OFF_SENSE)  ? rd_sense : 32'h00000000;

  // one wait state per access keeps every apb output on a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= access && !pready;
      pslverr <= access && !pready && !hit;
      prdata  <= (access && !pready && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // control and frame registers; a base write arms a flip for the next frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q   <= CTRL_RST;
      base_q   <= 24'h000000;
      win_q    <= 10'h000;
      stride_q <= 10'h000;
    end else begin
      if (wr_ctrl) ctrl_q <= pwdata[17:0];
      if (wr_base) base_q <= pwdata[F_ADDR +: 24];
      if (wr_strd) begin
        win_q    <= pwdata[W_WIDTH +: 10];
        stride_q <= pwdata[W_STRIDE +: 10];
      end
    end
  end

  // timing registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {hper_q, hend_q} <= 24'h000000;
      {hlen_q, hbeg_q} <= 20'h00000;
      {vper_q, vend_q} <= 22'h000000;
      {vlen_q, vbeg_q} <= 17'h00000;
    end else begin
      if (wr_hper) {hper_q, hend_q} <= {pwdata[T_HI +: 12], pwdata[11:0]};
      if (wr_hpul) {hlen_q, hbeg_q} <= {pwdata[T_HI +: 8], pwdata[11:0]};
      if (wr_vper) {vper_q, vend_q} <= {pwdata[T_HI +: 11], pwdata[10:0]};
      if (wr_vpul) {vlen_q, vbeg_q} <= {pwdata[T_HI +: 6], pwdata[10:0]};
    end
  end

  // control fields
  wire [1:0] fmt      = ctrl_q[C_FMT +: 2];
  wire       plane_on = ctrl_q[C_PLANE];
  wire [3:0] pan      = ctrl_q[C_PAN +: 4];
  wire       tim_on   = ctrl_q[C_TIMING];
  wire [1:0] lvl      = ctrl_q[C_LVL +: 2];

  // pixel clock pins cross over on two flops, the third finds the edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {pc_s1, pc_s2, pc_s3} <= 3'h0;
      {se_s1, se_s2}        <= 2'h0;
    end else begin
      {pc_s1, pc_s2, pc_s3} <= {pix_clk, pc_s1, pc_s2};
      {se_s1, se_s2}        <= {sense_hi, se_s1};
    end
  end

  // raster generator hookup
  assign t.run      = tim_on;
  assign t.pix_en   = pc_s2 && !pc_s3;
  assign t.h_period = hper_q;
  assign t.h_end    = hend_q;
  assign t.h_begin  = hbeg_q;
  assign t.h_len    = hlen_q;
  assign t.v_period = vper_q;
  assign t.v_end    = vend_q;
  assign t.v_begin  = vbeg_q;
  assign t.v_len    = vlen_q;

  sct_raster u_raster (
    .pclk    (pclk),
    .presetn (presetn),
    .t       (t)
  );

  // fetch control: a line is refetched after the visible part of the last one
  wire            run_fetch = tim_on && plane_on;
  wire            new_frame = !run_fetch || (t.act_end && t.last_line);
  wire            new_line  = t.act_end && !t.last_line;
  wire            flush     = new_frame || new_line;
  wire [21:0]     next_line = line_q + {12'h000, stride_q};
  wire [CW:0]     used      = {1'b0, cnt_q} + {{CW{1'b0}}, mem_req};
  wire [CW:0]     free      = (CW + 1)'(DEPTH) - used;
  wire            room      = free >= (CW + 1)'(sct_level(lvl));
  wire            can_req   = run_fetch && !mem_req && (left_q != 10'h000) &&
                              room && !flush;
  wire            push      = mem_req && mem_ack && !stale_q && !flush;

  // request issue; a flush during an outstanding request discards its data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_req   <= 1'b0;
      mem_addr  <= 28'h0000000;
      stale_q   <= 1'b0;
      frm_sel_q <= 2'h0;
      line_q    <= 22'h000000;
      ptr_q     <= 22'h000000;
      left_q    <= 10'h000;
      fline_q   <= 11'h000;
      flip_q    <= 1'b0;
    end else begin
      if (mem_req && mem_ack) begin
        mem_req <= 1'b0;
      end else if (can_req) begin
        mem_req  <= 1'b1;
        mem_addr <= {frm_sel_q, ptr_q, 4'h0};
      end
      stale_q <= flush ? (mem_req && !mem_ack) : (stale_q && !mem_ack);
      // a base write arms a flip; the frame reload clears it, the write wins
      flip_q  <= wr_base || (flip_q && !new_frame);
      if (new_frame) begin
        frm_sel_q <= base_q[23:22];
        line_q    <= base_q[21:0];
        ptr_q     <= base_q[21:0];
        left_q    <= win_q;
        fline_q   <= 11'h000;
      end else if (new_line) begin
        line_q  <= next_line;
        ptr_q   <= next_line;
        left_q  <= win_q;
        fline_q <= fline_q + 11'h001;
      end else if (can_req) begin
        ptr_q  <= ptr_q + 22'h000001;
        left_q <= left_q - 10'h001;
      end
    end
  end

  // pixel unpack: units hold 16, 8 or 4 pixels by format
  wire [3:0]  last_idx = (fmt == FMT_565) ? 4'h7 : (fmt == FMT_888) ? 4'h3 : 4'hf;
  wire        have     = (cnt_q != '0);
  wire        shown    = t.pix_en && t.active;
  wire        pop      = shown && have && (idx_q == last_idx) && !flush;
  wire [23:0] own_rgb  = (have && plane_on) ? sct_pixel(fifo_mem[rd_q], idx_q, fmt)
                                            : 24'h000000;

  // fifo storage keeps no reset, pointers and count do
  always_ff @(posedge pclk) begin
    if (push) fifo_mem[wr_q] <= mem_data;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
      idx_q <= 4'h0;
    end else if (flush) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
      idx_q <= pan & last_idx;
    end else begin
      if (push) wr_q <= wr_q + AW'(1);
      if (pop) rd_q <= rd_q + AW'(1);
      cnt_q <= cnt_q + CW'(push) - CW'(pop);
      if (shown && have) idx_q <= (idx_q == last_idx) ? 4'h0 : idx_q + 4'h1;
    end
  end

  // output selection: load sense overrides, then blanking, then source
  wire [23:0] src_rgb = ctrl_q[C_SRC] ? own_rgb : panel_rgb;
  wire [23:0] rgb_d   = ld_en_q ? ld_data_q :
                        (!t.active || ctrl_q[C_BLANK]) ? 24'h000000 : src_rgb;
  wire        gam_d   = ctrl_q[C_GAMMA] && plane_on && (fmt == FMT_565 || fmt == FMT_888);

  // monitor pins follow the pixel clock edge; polarity bits only invert
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rgb      <= 24'h000000;
      hsync    <= 1'b0;
      vsync    <= 1'b0;
      blank    <= 1'b1;
      gamma_on <= 1'b0;
    end else if (t.pix_en) begin
      rgb      <= rgb_d;
      hsync    <= t.hpulse ^ ctrl_q[C_HPOL];
      vsync    <= t.vpulse ^ ctrl_q[C_VPOL];
      blank    <= !t.active;
      gamma_on <= gam_d;
    end
  end

  // clock outputs track the synchronised pixel clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_clk <= 1'b0;
      tv_clk  <= 1'b0;
    end else begin
      mon_clk <= pc_s2 ^ ctrl_q[C_MPOL];
      tv_clk  <= pc_s2 ^ ctrl_q[C_TPOL];
    end
  end

  // signature over the displayed channel; 11 selects no channel
  wire [7:0] chan = (sigc_q[S_SEL +: 2] == CH_RED) ? rgb_d[23:16] :
                    (sigc_q[S_SEL +: 2] == CH_GRN) ? rgb_d[15:8] :
                    (sigc_q[S_SEL +: 2] == CH_BLU) ? rgb_d[7:0] : 8'h00;
  wire [15:0] sig_next = {sig_q[14:0], 1'b0} ^ (sig_q[15] ? SIG_TAPS : 16'h0000) ^
                         {8'h00, chan};

  // analyzer and load sense registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sigc_q    <= 4'h0;
      sig_q     <= 16'h0000;
      ld_en_q   <= 1'b0;
      ld_data_q <= 24'h000000;
    end else begin
      if (wr_sig) sigc_q <= pwdata[3:0];
      if (sigc_q[S_RST]) begin
        sig_q <= 16'h0000;
      end else if (sigc_q[S_EN] && shown) begin
        sig_q <= sig_next;
      end
      if (wr_sense) begin
        ld_en_q   <= pwdata[L_EN];
        ld_data_q <= pwdata[23:0];
      end
    end
  end
endmodule : sct_display

/* tb/sct_mem_model.sv */
// frame memory model on the fetch port of the display controller
// assumes one outstanding request at a time, same pclk as the controller
`timescale 1ns/1ps
module sct_mem_model (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // fetch port
  input  wire logic         mem_req,
  input  wire logic [3:0]   lag,
  output logic              mem_ack,
  output logic      [127:0] mem_data
);
  logic [3:0] wait_q;
  // every byte alike, so indexed and 8:8:8 pixels all decode to one colour
  wire [127:0] unit = {16{8'ha5}};
  // outside an acknowledge the lines carry the inverse, never the last unit
  assign mem_data = mem_ack ? unit : ~unit;
  // answer lag cycles after the request is seen, one-cycle acknowledge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q  <= 4'h0;
      mem_ack <= 1'b0;
    end else if (mem_ack || !mem_req) begin
      wait_q  <= 4'h0;
      mem_ack <= 1'b0;
    end else begin
      wait_q  <= wait_q + 4'h1;
      mem_ack <= wait_q >= lag;
    end
  end
endmodule : sct_mem_model

/* tb/sct_display_monitor.sv */
// port checker for the secondary display controller
// assumes it is bound onto every sct_display instance
`timescale 1ns/1ps
module sct_display_monitor (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [19:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // fetch port and clocks
  input wire logic        mem_req,
  input wire logic        mem_ack,
  input wire logic [27:0] mem_addr,
  input wire logic        pix_clk,
  input wire logic        mon_clk,
  input wire logic        tv_clk
);
  import sct_pkg::*;
  // word offsets that answer without an error
  wire mapped = paddr >= OFF_CTRL && paddr <= OFF_SENSE && paddr[1:0] == 2'h0;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_wait:
    assert property (psel && penable && !pready |=> pready) else $error("pready late");
  a_ready_pulse:
    assert property (pready |=> !pready) else $error("pready held");
  a_err_decode:
    assert property (pready |-> pslverr == !mapped) else $error("bad pslverr");
  a_idle_rdata:
    assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle");
  a_fetch_hold:
    assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
      else $error("fetch request dropped");
  a_fetch_gap:
    assert property (mem_req && mem_ack |=> !mem_req) else $error("no fetch gap");
  a_fetch_align:
    assert property (mem_req |-> mem_addr[3:0] == 4'h0) else $error("unaligned fetch");
  a_clk_follow:
    assert property ($rose(pix_clk) |-> ##3 ($changed(mon_clk) && $changed(tv_clk)))
      else $error("output clocks lag");
  c_err_seen: cover property (pready && pslverr);
  c_fetch_done: cover property (mem_req && mem_ack);
  c_fetch_slow: cover property (mem_req && !mem_ack ##1 mem_req && !mem_ack);
endmodule : sct_display_monitor

bind sct_display sct_display_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
  .mem_ack(mem_ack), .mem_addr(mem_addr), .pix_clk(pix_clk), .mon_clk(mon_clk),
  .tv_clk(tv_clk));

/* tb/sct_display_tb.sv */
// self-checking bench for the secondary display controller
// assumes sct_mem_model on the fetch port and the bound port checker
`timescale 1ns/1ps
module sct_display_tb;
  import sct_pkg::*;
  logic         pclk, presetn, psel, penable, pwrite, pix_clk, sense_hi;
  logic         pready, pslverr, mem_req, mem_ack, err;
  logic         hsync, vsync, blank, gamma_on, mon_clk, tv_clk;
  logic [3:0]   lag;
  logic [15:0]  sig;
  logic [19:0]  paddr;
  logic [23:0]  panel_rgb, rgb;
  logic [27:0]  mem_addr, last_addr;
  logic [31:0]  pwdata, prdata, rd;
  logic [127:0] mem_data;
  int           mismatches, cmp_count, hs, vs, act, hit, gam;
  // map, read-back after writing ones to all but the timing enable, and a 16x6 raster with 8x3 visible
  logic [19:0]  offs [10] = '{OFF_CTRL, OFF_BASE, OFF_STRIDE, OFF_HPER, OFF_HPUL,
                              OFF_VPER, OFF_VPUL, OFF_SIG, OFF_LINE, OFF_SENSE};
  logic [31:0]  back [10] = '{32'h0003f6ff, 32'h0ffffff0, 32'h3ff03ff0, 32'h0fff0fff,
                              32'h00ff0fff, 32'h07ff07ff, 32'h003f07ff, 32'h0000000f,
                              32'h00000000, 32'h03ffffff};
  logic [31:0]  cfg [10]  = '{32'h0, 32'h0, 32'h00200020, 32'h000f0007, 32'h0002000a,
                              32'h00050002, 32'h00010003, 32'h0, 32'h0, 32'h0};
  // bus clock and a free pixel clock 32 times slower, rising on falling bus clock edges
  always #2.5 pclk = ~pclk;
  always #80 pix_clk = ~pix_clk;
  sct_display uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_data(mem_data),
    .pix_clk(pix_clk), .panel_rgb(panel_rgb), .sense_hi(sense_hi), .rgb(rgb),
    .hsync(hsync), .vsync(vsync), .blank(blank), .gamma_on(gamma_on), .mon_clk(mon_clk),
    .tv_clk(tv_clk));
  sct_mem_model mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .lag(lag),
                     .mem_ack(mem_ack), .mem_data(mem_data));
  // last unit address the memory answered, for the reload check
  always @(posedge pclk) begin
    if (mem_req && mem_ack) last_addr <= mem_addr;
  end
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  // one transfer: setup, access held until pready, then release
  task automatic apb(input logic wr, input logic [19:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      wrap_up();
    end
  endtask : apb
  // one frame of 96 pixels, pins sampled once each pixel enable has landed
  task automatic frame(input logic [23:0] want);
    hs = 0;
    vs = 0;
    act = 0;
    hit = 0;
    gam = 0;
    repeat (96) begin
      @(posedge pix_clk);
      repeat (6) @(posedge pclk);
      hs += int'(hsync === 1'b1);
      vs += int'(vsync === 1'b1);
      act += int'(blank === 1'b0);
      hit += int'(blank === 1'b0 && rgb === want);
      gam += int'(gamma_on === 1'b1);
    end
  endtask : frame
  // first frame after a change may be partial, so only the second counts
  task automatic show(input logic [31:0] c, input logic [23:0] want);
    apb(1'b1, OFF_CTRL, c);
    frame(want);
    frame(want);
  endtask : show
  initial begin
    pclk = 1'b0;
    pix_clk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 20'h0;
    pwdata = 32'h0;
    sense_hi = 1'b1;
    panel_rgb = 24'h123456;
    lag = 4'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, then every field but the timing enable written with ones and read back
    for (int i = 0; i < 10; i++) begin
      apb(1'b0, offs[i], 32'h0);
      cmp(rd, i == 0 ? 32'h00010000 : i == 9 ? 32'h02000000 : 32'h0);
      apb(1'b1, offs[i], i == 0 ? 32'hfffffeff : 32'hffffffff);
      apb(1'b0, offs[i], 32'h0);
      cmp(rd, back[i]);
    end
    // all polarities inverted with timing off, test colour forced
    @(posedge pix_clk);
    repeat (6) @(posedge pclk);
    cmp({4'h0, mon_clk, tv_clk, hsync, vsync, rgb}, {8'h03, 24'hffffff});
    // unmapped word: error, no data, write dropped
    apb(1'b1, 20'h80228, 32'hffffffff);
    cmp({31'h0, err}, 32'h1);
    apb(1'b0, 20'h80228, 32'h0);
    cmp({err, rd[30:0]}, 32'h80000000);
    for (int i = 0; i < 10; i++) begin
      apb(1'b1, offs[i], cfg[i]);
    end
    // comparator low, test colour off
    sense_hi <= 1'b0;
    apb(1'b0, OFF_SENSE, 32'h0);
    cmp(rd, 32'h0);
    // gamma asked in each format; indexed shows grey, slow memory on 8:8:8
    for (int f = 0; f < 3; f++) begin
      lag <= f == 2 ? 4'h9 : 4'h0;
      show(32'h0003030c + 32'(f), 24'ha5a5a5);
      cmp(hs, 12);
      cmp(vs, 16);
      cmp(act, 24);
      cmp(gam != 0, f != 0);
      if (f != 1) cmp(hit, 24);
    end
    // a base written while running stays pending until the frame reload
    apb(1'b1, OFF_BASE, 32'h00000100);
    apb(1'b0, OFF_BASE, 32'h0);
    cmp(rd, 32'h80000100);
    frame(24'ha5a5a5);
    apb(1'b0, OFF_BASE, 32'h0);
    cmp(rd, 32'h00000100);
    cmp({4'h0, last_addr}, 32'h00000110);
    show(32'h00030706, 24'h0);
    cmp(hit, 24);
    show(32'h00030106, 24'h123456);
    cmp(hit, 24);
    // pan by one: two units cover only seven of eight visible pixels
    show(32'h00030316, 24'ha5a5a5);
    cmp(hit, 21);
    show(32'h00030006, 24'h0);
    cmp(hs + vs, 0);
    // green signature over exactly one frame, then held in reset
    show(32'h00030306, 24'ha5a5a5);
    apb(1'b1, OFF_SIG, 32'h4);
    apb(1'b1, OFF_SIG, 32'h9);
    frame(24'ha5a5a5);
    apb(1'b1, OFF_SIG, 32'h1);
    apb(1'b0, OFF_SIG, 32'h0);
    sig = 16'h0;
    repeat (24) sig = {sig[14:0], 1'b0} ^ (sig[15] ? SIG_TAPS : 16'h0) ^ 16'h00a5;
    cmp(rd, {sig, 16'h0001});
    apb(1'b1, OFF_SIG, 32'h4);
    apb(1'b0, OFF_SIG, 32'h0);
    cmp(rd, 32'h4);
    wrap_up();
  end
endmodule : sct_display_tb
